//--- rcf_cfg.svh
`ifndef RCF_CFG_SVH
`define RCF_CFG_SVH

// Register offsets (byte addresses on the plain register port).
`define RCF_ADDR_W          8
`define RCF_STATUS_OFS      8'h00
`define RCF_CLEAR_OFS       8'h04
`define RCF_LAST_OFS        8'h08
`define RCF_COUNT_OFS       8'h0c

// Field positions in the status register.
`define RCF_FLAG_W          10
`define RCF_BIT_POWER_UP    0
`define RCF_BIT_BROWNOUT    1
`define RCF_BIT_WAKE_IDLE   2
`define RCF_BIT_WAKE_SLEEP  3
`define RCF_BIT_WATCHDOG    4
`define RCF_BIT_SOFTWARE    6
`define RCF_BIT_EXT_PIN     7
`define RCF_BIT_REG_STBY    8
`define RCF_BIT_CFG_MISM    9

// Reset value and implemented-bit mask of the status register.
`define RCF_STATUS_RESET    10'h003
`define RCF_STATUS_MASK     10'h3df

// Width of the saturating counter of warm resets.
`define RCF_COUNT_W         8
`define RCF_COUNT_MAX       8'hff

`endif

//--- rcf_pkg.sv
package rcf_pkg;

    // Power mode of the core as seen by the reset-cause block.
    typedef enum logic [2:0] {
        RCF_MODE_RUN   = 3'b001,
        RCF_MODE_IDLE  = 3'b010,
        RCF_MODE_SLEEP = 3'b100
    } rcf_mode_t;

    // Code of the most recent reset cause, shown in the snapshot register.
    typedef enum logic [2:0] {
        RCF_CAUSE_POWER_UP = 3'h0,
        RCF_CAUSE_BROWNOUT = 3'h1,
        RCF_CAUSE_WATCHDOG = 3'h2,
        RCF_CAUSE_SOFTWARE = 3'h3,
        RCF_CAUSE_EXT_PIN  = 3'h4,
        RCF_CAUSE_CFG_MISM = 3'h5,
        RCF_CAUSE_WAKE     = 3'h6
    } rcf_cause_t;

endpackage : rcf_pkg

//--- rcf_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none

module rcf_flag_bank #(
    parameter int unsigned           WIDTH     = 10,
    parameter logic [WIDTH-1:0]      RESET_VAL = '0,
    parameter logic [WIDTH-1:0]      IMPL_MASK = '1
) (
    input  wire logic                core_clk_i,
    input  wire logic                reset_i,
    input  wire logic [WIDTH-1:0]    set_i,
    input  wire logic                wr_i,
    input  wire logic [WIDTH-1:0]    wdata_i,
    input  wire logic [WIDTH-1:0]    clr_i,
    output logic      [WIDTH-1:0]    flags_o
);

    logic [WIDTH-1:0] flag_q;
    logic [WIDTH-1:0] flag_d;

    // One sticky bit per position; a hardware set beats any software write or clear
    // in the same cycle so that an event is never lost.
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_comb begin
            flag_d[b] = flag_q[b] & ~clr_i[b];
            if (wr_i) begin
                flag_d[b] = wdata_i[b];
            end
            flag_d[b] = (flag_d[b] | set_i[b]) & IMPL_MASK[b];
        end

        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                flag_q[b] <= RESET_VAL[b];
            end else begin
                flag_q[b] <= flag_d[b];
            end
        end
    end

    assign flags_o = flag_q;

endmodule : rcf_flag_bank

`default_nettype wire

//--- rcf_power_mode.sv
`timescale 1ns/10ps
`default_nettype none

module rcf_power_mode (
    input  wire logic                core_clk_i,
    input  wire logic                reset_i,
    input  wire logic                enter_sleep_i,
    input  wire logic                enter_idle_i,
    input  wire logic                wake_i,
    input  wire logic                stay_on_i,
    output rcf_pkg::rcf_mode_t       mode_o,
    output logic                     was_sleep_o,
    output logic                     was_idle_o,
    output logic                     regulator_standby_o
);

    rcf_pkg::rcf_mode_t mode_q;
    rcf_pkg::rcf_mode_t mode_d;

    // Track the low-power mode; any wake or reset event returns the core to run.
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            rcf_pkg::RCF_MODE_RUN: begin
                if (enter_sleep_i) begin
                    mode_d = rcf_pkg::RCF_MODE_SLEEP;
                end else if (enter_idle_i) begin
                    mode_d = rcf_pkg::RCF_MODE_IDLE;
                end
            end
            rcf_pkg::RCF_MODE_IDLE: begin
                if (wake_i) begin
                    mode_d = rcf_pkg::RCF_MODE_RUN;
                end
            end
            rcf_pkg::RCF_MODE_SLEEP: begin
                if (wake_i) begin
                    mode_d = rcf_pkg::RCF_MODE_RUN;
                end
            end
            default: begin
                mode_d = rcf_pkg::RCF_MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= rcf_pkg::RCF_MODE_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // The mode held before the wake is what gets reported.
    assign was_sleep_o = wake_i && (mode_q == rcf_pkg::RCF_MODE_SLEEP);
    assign was_idle_o  = wake_i && (mode_q == rcf_pkg::RCF_MODE_IDLE);
    assign mode_o      = mode_q;

    // In sleep the regulator tracks in standby unless software keeps it on.
    assign regulator_standby_o = (mode_q == rcf_pkg::RCF_MODE_SLEEP) && !stay_on_i; // RULE2

endmodule : rcf_power_mode

`default_nettype wire

//--- rcf_reset_cause.sv
// Notes on behaviour
// RULE1 - A configuration-mismatch reset sets bit 9; zero means none occurred.
// RULE2 - Bit 8 high keeps the regulator on in sleep; low lets it standby-track.
// RULE3 - A reset from the master-clear pin sets bit 7.
// RULE4 - An executed software reset sets bit 6.
// RULE5 - A watchdog timer time-out sets bit 4.
// RULE6 - Bit 3 is set when the device was in sleep before the wake or reset.
// RULE7 - Bit 2 is set when the device was in idle before the wake or reset.
// RULE8 - A brown-out reset sets bit 1.
// RULE9 - A power-on reset sets bit 0.
// RULE10 - Software clears brown-out and power-up bits to see the next such event.
// RULE11 - Flags are set by hardware, read/write to software; power-on gives bits 1,0 set.
// RULE12 - Bits 31 to 10 and bit 5 read zero and ignore writes.
// RULE13 - Only power-on reset clears the flags; warm resets leave them standing.
`timescale 1ns/10ps
`default_nettype none
`include "rcf_cfg.svh"

module rcf_reset_cause #(
    parameter int unsigned ADDR_W = `RCF_ADDR_W
) (
    input  wire logic                core_clk_i,
    input  wire logic                reset_i,
    // Register port.
    input  wire logic [ADDR_W-1:0]   reg_addr_i,
    input  wire logic [31:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [31:0]         reg_rdata_o,
    // Reset and wake causes, levels from the reset generator.
    input  wire logic                config_mismatch_i,
    input  wire logic                master_clear_pin_i,
    input  wire logic                software_reset_i,
    input  wire logic                watchdog_timer_timeout_i,
    input  wire logic                brownout_i,
    input  wire logic                power_up_i,
    // Core power mode requests and wake event.
    input  wire logic                enter_sleep_i,
    input  wire logic                enter_idle_i,
    input  wire logic                wake_i,
    // Status toward the rest of the chip.
    output logic                     regulator_standby_o,
    output logic                     regulator_stay_on_o,
    output rcf_pkg::rcf_mode_t       power_mode_o
);

    localparam int unsigned FW = `RCF_FLAG_W;
    localparam int unsigned CW = `RCF_COUNT_W;

    // Cause inputs are levels that may stay high for many cycles while the
    // reset generator holds the core; only the rising edge counts, so a flag
    // cleared by software is not set again by the same event.
    logic [5:0] cause_lvl;
    logic [5:0] cause_prev_q;
    logic [5:0] cause_prev_d;
    logic [5:0] cause_rise;

    assign cause_lvl = {config_mismatch_i, master_clear_pin_i, software_reset_i,
                        watchdog_timer_timeout_i, brownout_i, power_up_i};

    always_comb begin
        cause_prev_d = cause_lvl;
        cause_rise   = cause_lvl & ~cause_prev_q;
    end

    // The previous level resets high so that a cause still asserted as
    // power-on reset lifts is not counted a second time.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cause_prev_q <= 6'h3f;
        end else begin
            cause_prev_q <= cause_prev_d;
        end
    end

    // Individual edge pulses, named from the flag they feed.
    logic rise_cfg_mism;
    logic rise_ext_pin;
    logic rise_software;
    logic rise_watchdog;
    logic rise_brownout;
    logic rise_power_up;
    logic warm_reset;
    logic any_wake;

    assign rise_cfg_mism = cause_rise[5];
    assign rise_ext_pin  = cause_rise[4];
    assign rise_software = cause_rise[3];
    assign rise_watchdog = cause_rise[2];
    assign rise_brownout = cause_rise[1];
    assign rise_power_up = cause_rise[0];

    // Warm resets are every cause except power-up; they only add flags.
    assign warm_reset = rise_cfg_mism | rise_ext_pin | rise_software
                      | rise_watchdog | rise_brownout; // RULE13
    // A reset event also ends sleep or idle, so it counts as a wake.
    assign any_wake   = wake_i | warm_reset | rise_power_up;

    // Register decode.
    logic status_sel;
    logic clear_sel;
    logic last_sel;
    logic count_sel;

    assign status_sel = (reg_addr_i == ADDR_W'(`RCF_STATUS_OFS));
    assign clear_sel  = (reg_addr_i == ADDR_W'(`RCF_CLEAR_OFS));
    assign last_sel   = (reg_addr_i == ADDR_W'(`RCF_LAST_OFS));
    assign count_sel  = (reg_addr_i == ADDR_W'(`RCF_COUNT_OFS));

    // Power mode tracking and regulator control.
    logic               was_sleep;
    logic               was_idle;
    logic [FW-1:0]      flags;
    logic               stay_on;

    assign stay_on = flags[`RCF_BIT_REG_STBY];

    rcf_power_mode u_power_mode (
        .core_clk_i          (core_clk_i),
        .reset_i             (reset_i),
        .enter_sleep_i       (enter_sleep_i),
        .enter_idle_i        (enter_idle_i),
        .wake_i              (any_wake),
        .stay_on_i           (stay_on),
        .mode_o              (power_mode_o),
        .was_sleep_o         (was_sleep),
        .was_idle_o          (was_idle),
        .regulator_standby_o (regulator_standby_o)
    );

    assign regulator_stay_on_o = stay_on; // RULE2

    // Hardware set vector for the sticky flags.
    logic [FW-1:0] flag_set;

    always_comb begin
        flag_set                       = '0;
        flag_set[`RCF_BIT_CFG_MISM]    = rise_cfg_mism; // RULE1
        flag_set[`RCF_BIT_EXT_PIN]     = rise_ext_pin;  // RULE3
        flag_set[`RCF_BIT_SOFTWARE]    = rise_software; // RULE4
        flag_set[`RCF_BIT_WATCHDOG]    = rise_watchdog; // RULE5
        flag_set[`RCF_BIT_WAKE_SLEEP]  = was_sleep;     // RULE6
        flag_set[`RCF_BIT_WAKE_IDLE]   = was_idle;      // RULE7
        flag_set[`RCF_BIT_BROWNOUT]    = rise_brownout; // RULE8
        flag_set[`RCF_BIT_POWER_UP]    = rise_power_up; // RULE9
    end

    // Writes to the status word store the low bits; the clear alias takes
    // ones as clears, which spares software a read-modify-write that could
    // drop a flag set between its read and its write.
    logic          status_wr;
    logic [FW-1:0] clear_vec;

    assign status_wr = reg_wr_i && status_sel; // RULE11
    assign clear_vec = (reg_wr_i && clear_sel) ? reg_wdata_i[FW-1:0] : '0; // RULE10

    // Flag bank: reset value has power-up and brown-out set, the mask keeps
    // bit 5 at zero whatever is written.
    rcf_flag_bank #(
        .WIDTH     (FW),
        .RESET_VAL (`RCF_STATUS_RESET), // RULE11
        .IMPL_MASK (`RCF_STATUS_MASK)   // RULE12
    ) u_flag_bank (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .set_i      (flag_set),
        .wr_i       (status_wr),
        .wdata_i    (reg_wdata_i[FW-1:0]),
        .clr_i      (clear_vec),
        .flags_o    (flags)
    );

    // Snapshot of the most recent cause; the highest-priority cause wins when
    // several rise together, the master-clear pin being the most deliberate.
    rcf_pkg::rcf_cause_t last_q;
    rcf_pkg::rcf_cause_t last_d;

    always_comb begin
        last_d = last_q;
        if (rise_ext_pin) begin
            last_d = rcf_pkg::RCF_CAUSE_EXT_PIN;
        end else if (rise_cfg_mism) begin
            last_d = rcf_pkg::RCF_CAUSE_CFG_MISM;
        end else if (rise_watchdog) begin
            last_d = rcf_pkg::RCF_CAUSE_WATCHDOG;
        end else if (rise_software) begin
            last_d = rcf_pkg::RCF_CAUSE_SOFTWARE;
        end else if (rise_brownout) begin
            last_d = rcf_pkg::RCF_CAUSE_BROWNOUT;
        end else if (rise_power_up) begin
            last_d = rcf_pkg::RCF_CAUSE_POWER_UP;
        end else if (was_sleep || was_idle) begin
            last_d = rcf_pkg::RCF_CAUSE_WAKE;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            last_q <= rcf_pkg::RCF_CAUSE_POWER_UP;
        end else begin
            last_q <= last_d;
        end
    end

    // Saturating count of warm resets since power-on or since software last
    // wrote the counter; a new reset in the write cycle still counts.
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (reg_wr_i && count_sel) begin
            count_d = '0;
        end
        if (warm_reset && (count_d != CW'(`RCF_COUNT_MAX))) begin
            count_d = count_d + CW'(1);
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // Read data register: valid in the cycle after the read strobe only;
    // unmapped addresses and unimplemented bits answer zero.
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = '0;
        if (reg_rd_i) begin
            if (status_sel) begin
                rdata_d[FW-1:0] = flags; // RULE12
            end else if (last_sel) begin
                rdata_d[2:0] = last_q;
            end else if (count_sel) begin
                rdata_d[CW-1:0] = count_q;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule : rcf_reset_cause

`default_nettype wire

//--- rcf_reset_cause_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcf_cfg.svh"

module rcf_reset_cause_props #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic               core_clk_i,
    input wire logic               reset_i,
    input wire logic [ADDR_W-1:0]  reg_addr_i,
    input wire logic [31:0]        reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [31:0]        reg_rdata_o,
    input wire logic               config_mismatch_i,
    input wire logic               master_clear_pin_i,
    input wire logic               software_reset_i,
    input wire logic               watchdog_timer_timeout_i,
    input wire logic               brownout_i,
    input wire logic               power_up_i,
    input wire logic               wake_i,
    input wire logic               regulator_standby_o,
    input wire logic               regulator_stay_on_o,
    input wire rcf_pkg::rcf_mode_t power_mode_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    logic [1:0] age_q;
    logic [1:0] age_d;
    logic       st_rd;
    logic       st_wr;

    // Edge detectors are blind just after reset, so a rise only counts once this saturates.
    always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) age_q <= 2'h0;
        else age_q <= age_d;
    end

    // Status register accesses.
    assign st_rd = reg_rd_i && (reg_addr_i == `RCF_STATUS_OFS);
    assign st_wr = reg_wr_i && (reg_addr_i == `RCF_STATUS_OFS);

    // A cause rise is followed by a quiet cycle with no write that could clear the
    // flag, then the status read whose data must show it.
    AST_CFG_MISM: assert property ((age_q == 2'h3) && $rose(config_mismatch_i)
        ##1 !reg_wr_i ##1 st_rd |=> reg_rdata_o[9]) else $error("mismatch flag not set");
    AST_EXT_PIN: assert property ((age_q == 2'h3) && $rose(master_clear_pin_i)
        ##1 !reg_wr_i ##1 st_rd |=> reg_rdata_o[7]) else $error("pin flag not set");
    AST_SOFTWARE: assert property ((age_q == 2'h3) && $rose(software_reset_i)
        ##1 !reg_wr_i ##1 st_rd |=> reg_rdata_o[6]) else $error("software flag not set");
    AST_WATCHDOG: assert property ((age_q == 2'h3) && $rose(watchdog_timer_timeout_i)
        ##1 !reg_wr_i ##1 st_rd |=> reg_rdata_o[4]) else $error("watchdog flag not set");
    AST_BROWNOUT: assert property ((age_q == 2'h3) && $rose(brownout_i)
        ##1 !reg_wr_i ##1 st_rd |=> reg_rdata_o[1]) else $error("brownout flag not set");
    AST_POWER_UP: assert property ((age_q == 2'h3) && $rose(power_up_i)
        ##1 !reg_wr_i ##1 st_rd |=> reg_rdata_o[0]) else $error("power-up flag not set");
    AST_UNIMPL: assert property (st_rd |=> reg_rdata_o[31:10] == 22'h0 && !reg_rdata_o[5])
        else $error("unimplemented status bits not zero");
    AST_STANDBY: assert property (regulator_standby_o ==
        (power_mode_o == rcf_pkg::RCF_MODE_SLEEP && !regulator_stay_on_o))
        else $error("regulator standby wrong");
    AST_STAY_ON: assert property (st_wr |=> regulator_stay_on_o == $past(reg_wdata_i[8]))
        else $error("stay-on control not written");
    AST_WAKE_SLEEP: assert property (power_mode_o == rcf_pkg::RCF_MODE_SLEEP && wake_i
        ##1 !reg_wr_i ##1 st_rd |=> reg_rdata_o[3]) else $error("sleep wake flag not set");
    AST_WAKE_IDLE: assert property (power_mode_o == rcf_pkg::RCF_MODE_IDLE && wake_i
        ##1 !reg_wr_i ##1 st_rd |=> reg_rdata_o[2]) else $error("idle wake flag not set");
endmodule : rcf_reset_cause_props

bind rcf_reset_cause rcf_reset_cause_props #(.ADDR_W(ADDR_W)) u_props (
    .core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .config_mismatch_i, .master_clear_pin_i, .software_reset_i, .watchdog_timer_timeout_i,
    .brownout_i, .power_up_i, .wake_i, .regulator_standby_o, .regulator_stay_on_o,
    .power_mode_o
);

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcf_cfg.svh"

module tb_top;
    logic               core_clk_i = 1'b0;
    logic               reset_i    = 1'b1;
    logic [7:0]         addr       = 8'h00;
    logic [31:0]        wdata      = 32'h0;
    logic               wr         = 1'b0;
    logic               rd         = 1'b0;
    logic [9:0]         ev         = 10'h000;
    logic [31:0]        rdata;
    logic               stby;
    logic               stay;
    rcf_pkg::rcf_mode_t mode;
    int                 fails      = 0;
    int                 checked    = 0;
    int                 cbit[6]    = '{9, 7, 6, 4, 1, 0};

    // Event lines sit at the index of the status bit they set; 2, 3, 5 drive the power mode.
    rcf_reset_cause #(.ADDR_W(8)) dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .config_mismatch_i(ev[9]), .master_clear_pin_i(ev[7]), .software_reset_i(ev[6]),
        .watchdog_timer_timeout_i(ev[4]), .brownout_i(ev[1]), .power_up_i(ev[0]),
        .enter_sleep_i(ev[3]), .enter_idle_i(ev[2]), .wake_i(ev[5]),
        .regulator_standby_o(stby), .regulator_stay_on_o(stay), .power_mode_o(mode));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Each access starts on a rising edge and ends one gap cycle later on an edge, so
    // a strobe is never raised in the same step in which it was lowered.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk_i);
        wr <= 1'b0;
        @(posedge core_clk_i);
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so they are taken 1 ns into it.
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
        @(posedge core_clk_i);
    endtask : rd_reg

    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge core_clk_i);
        ev[k] <= 1'b0;
        @(posedge core_clk_i);
    endtask : pulse

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // The whole sequence needs about 110 cycles; this cuts a hang short.
    initial begin
        #20000;
        fails++;
        end_sim();
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        rd_reg(`RCF_STATUS_OFS, 32'h3, "status after reset");
        rd_reg(8'h10, 32'h0, "unmapped read");
        wr_reg(`RCF_STATUS_OFS, 32'hffffffff);
        rd_reg(`RCF_STATUS_OFS, 32'h3df, "status all ones");
        #1;
        chk("stay on", 32'h1, {31'h0, stay});
        @(posedge core_clk_i);
        // The clear alias drops only the bits written as ones and reads back zero.
        wr_reg(`RCF_CLEAR_OFS, 32'h3);
        rd_reg(`RCF_STATUS_OFS, 32'h3dc, "clear alias");
        rd_reg(`RCF_CLEAR_OFS, 32'h0, "clear alias read");
        wr_reg(`RCF_STATUS_OFS, 32'h0);
        rd_reg(`RCF_STATUS_OFS, 32'h0, "status cleared");
        $display("test registers done");
        foreach (cbit[j]) begin
            pulse(cbit[j]);
            rd_reg(`RCF_STATUS_OFS, 32'h1 << cbit[j], "cause flag");
            wr_reg(`RCF_STATUS_OFS, 32'h0);
        end
        // A brown-out level held high sets its flag once; after a clear it stays clear.
        ev[1] <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        wr_reg(`RCF_STATUS_OFS, 32'h0);
        rd_reg(`RCF_STATUS_OFS, 32'h0, "level held high");
        ev[1] <= 1'b0;
        @(posedge core_clk_i);
        $display("test causes done");
        pulse(5);
        rd_reg(`RCF_STATUS_OFS, 32'h0, "wake in run");
        pulse(3);
        #1;
        chk("standby in sleep", 32'h1, {31'h0, stby});
        @(posedge core_clk_i);
        pulse(5);
        rd_reg(`RCF_STATUS_OFS, 32'h8, "wake from sleep");
        #1;
        chk("mode after wake", 32'h1, {29'h0, mode});
        @(posedge core_clk_i);
        wr_reg(`RCF_STATUS_OFS, 32'h100);
        pulse(3);
        #1;
        chk("standby kept off", 32'h0, {31'h0, stby});
        @(posedge core_clk_i);
        pulse(5);
        wr_reg(`RCF_STATUS_OFS, 32'h0);
        pulse(2);
        pulse(5);
        rd_reg(`RCF_STATUS_OFS, 32'h4, "wake from idle");
        $display("test power modes done");
        wr_reg(`RCF_STATUS_OFS, 32'h0);
        wr_reg(`RCF_COUNT_OFS, 32'h0);
        pulse(7);
        rd_reg(`RCF_LAST_OFS, 32'h4, "last pin cause");
        pulse(4);
        rd_reg(`RCF_STATUS_OFS, 32'h90, "flags kept");
        rd_reg(`RCF_COUNT_OFS, 32'h2, "warm count");
        rd_reg(`RCF_LAST_OFS, 32'h2, "last cause");
        reset_i <= 1'b1;
        @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        rd_reg(`RCF_STATUS_OFS, 32'h3, "status after second reset");
        $display("test warm resets done");
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
